// *** rtl/rtc_pkg.sv ***
// Shared constants and carrier types for the seconds/minutes and correction core
package rtc_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_SCRATCH  = 8'h03;
   localparam logic [7:0] ADDR_SECONDS  = 8'h04;
   localparam logic [7:0] ADDR_MINUTES  = 8'h05;
   localparam logic [7:0] SCRATCH_RESET = 8'h00;
   localparam logic [6:0] TIME_RESET    = 7'h00;
   localparam logic [7:0] READ_NONE     = 8'h00;
   localparam int         HALT_BIT      = 7;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int         XTAL_HZ       = 32768;
   localparam int         CORR_HZ       = 1024;
   localparam int         LOW_DIV       = XTAL_HZ / CORR_HZ;
   localparam logic [4:0] LOW_MAX       = 5'(LOW_DIV - 1);
   localparam int         OSC_STABLE_MS = 200;
   localparam int         OSC_STABLE_TICKS = (XTAL_HZ * OSC_STABLE_MS + 999) / 1000;

   // ----------------------------------------------------------------
   // Fast correction schedule
   // ----------------------------------------------------------------
   localparam logic [6:0] LAST_SEC      = 7'h3b;
   localparam logic [1:0] TRIG_MIN_MOD4 = 2'h0;
   localparam logic [2:0] MAX_PULSES    = 3'h5;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rtc_reg_req_t;

   typedef struct packed {
      logic       fast_mode;
      logic       correction_irq_enable;
      logic [6:0] offset;
   } rtc_corr_cfg_t;
endpackage : rtc_pkg

// *** rtl/rtc_core.sv ***
// Seconds/minutes counters, oscillator-stop flag, scratch byte and fast correction
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/10ps
module rtc_core #(
   parameter int OSC_STABLE_TICKS = rtc_pkg::OSC_STABLE_TICKS
) (
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   input  wire logic                  xtal_tick,
   input  wire logic                  osc_running,
   input  wire rtc_pkg::rtc_reg_req_t reg_req,
   input  wire rtc_pkg::rtc_corr_cfg_t cfg,
   output logic [7:0]                 reg_rdata,
   output logic                       int_n,
   output logic                       tick_64hz,
   output logic                       tick_1hz,
   output logic                       tick_1_60hz,
   output logic                       divided_clock_output
);

   function automatic logic [6:0] bcd2bin(input logic [6:0] b);
      bcd2bin = 7'({b[6:4], 3'h0} + {b[6:4], 1'h0} + {3'h0, b[3:0]});
   endfunction : bcd2bin

   function automatic logic [6:0] bcd_next(input logic [6:0] b);
      if (bcd2bin(b) == rtc_pkg::LAST_SEC)
         bcd_next = rtc_pkg::TIME_RESET;
      else if (b[3:0] == 4'h9)
         bcd_next = {3'(b[6:4] + 3'h1), 4'h0};
      else
         bcd_next = {b[6:4], 4'(b[3:0] + 4'h1)};
   endfunction : bcd_next

   logic [4:0]  low_cnt_r;
   logic [9:0]  hi_cnt_r;
   logic [6:0]  sec_r;
   logic [6:0]  min_r;
   logic        halt_r;
   logic [7:0]  scratch_r;
   logic [12:0] stable_cnt_r;
   logic        osc_ok_r;
   logic        act_r;
   logic        sign_r;
   logic [6:0]  mag_r;
   logic [2:0]  pend_r;
   logic        gap_r;

   // ----------------------------------------------------------------
   // Divider and correction step
   // ----------------------------------------------------------------
   wire        low_wrap = xtal_tick && (low_cnt_r == rtc_pkg::LOW_MAX);
   wire        corr_now = low_wrap && (pend_r != 3'h0) && !gap_r;
   wire [1:0]  hi_step  = corr_now ? (sign_r ? 2'h0 : 2'h2) : 2'h1;
   wire [10:0] hi_sum   = {1'b0, hi_cnt_r} + {9'h0, hi_step};
   wire [9:0]  hi_nxt   = hi_sum[9:0];
   wire        sec_tick = low_wrap && hi_sum[10];
   wire        t64      = low_wrap && (hi_nxt[9:4] != hi_cnt_r[9:4]);

   // ----------------------------------------------------------------
   // Time counters and schedule
   // ----------------------------------------------------------------
   wire       sec_wrap = bcd2bin(sec_r) == rtc_pkg::LAST_SEC;
   wire       min_tick = sec_tick && sec_wrap;
   wire [6:0] sec_nxt  = bcd_next(sec_r);
   wire [6:0] min_nxt  = bcd_next(min_r);
   wire [6:0] min_bin  = bcd2bin(min_nxt);
   wire [6:0] nsec_bin = bcd2bin(sec_nxt);
   // Mode is only looked at here, so a change waits for the next trigger
   wire       trigger  = min_tick && cfg.fast_mode && (min_bin[1:0] == rtc_pkg::TRIG_MIN_MOD4);
   wire [6:0] mag_in   = cfg.offset[6] ? 7'(-cfg.offset) : cfg.offset;
   wire [6:0] mag_use  = trigger ? mag_in : mag_r;
   wire [6:0] extra    = 7'(mag_use - rtc_pkg::LAST_SEC);
   wire [2:0] load_cnt = (nsec_bin < rtc_pkg::LAST_SEC) ? {2'h0, nsec_bin < mag_use}
                       : ((mag_use > rtc_pkg::LAST_SEC) ? extra[2:0] : 3'h0);
   wire       in_win   = trigger || act_r;

   wire wr_scr = reg_req.wr && (reg_req.addr == rtc_pkg::ADDR_SCRATCH);
   wire wr_sec = reg_req.wr && (reg_req.addr == rtc_pkg::ADDR_SECONDS);
   wire wr_min = reg_req.wr && (reg_req.addr == rtc_pkg::ADDR_MINUTES);

   // Stop condition set wins over a clearing write
   wire halt_nxt = !osc_ok_r ? 1'b1
                 : (wr_sec ? reg_req.wdata[rtc_pkg::HALT_BIT] : halt_r);

   wire [7:0] rd_mux = (reg_req.addr == rtc_pkg::ADDR_SCRATCH) ? scratch_r
                     : (reg_req.addr == rtc_pkg::ADDR_SECONDS) ? {halt_r, sec_r}
                     : (reg_req.addr == rtc_pkg::ADDR_MINUTES) ? {1'b0, min_r}
                     : rtc_pkg::READ_NONE;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         low_cnt_r <= 5'h00;
         hi_cnt_r  <= 10'h000;
      end
      else if (xtal_tick)
      begin
         low_cnt_r <= low_wrap ? 5'h00 : 5'(low_cnt_r + 5'h01);
         if (low_wrap)
            hi_cnt_r <= hi_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sec_r     <= rtc_pkg::TIME_RESET;
         min_r     <= rtc_pkg::TIME_RESET;
         scratch_r <= rtc_pkg::SCRATCH_RESET;
         halt_r    <= 1'b1;
      end
      else
      begin
         halt_r <= halt_nxt;
         if (wr_scr)
            scratch_r <= reg_req.wdata;
         if (wr_sec)
            sec_r <= reg_req.wdata[6:0];
         else if (sec_tick)
            sec_r <= sec_nxt;
         if (wr_min)
            min_r <= reg_req.wdata[6:0];
         else if (min_tick)
            min_r <= min_nxt;
      end
   end

   // Crystal must run unbroken for the settle time before it counts as running
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stable_cnt_r <= 13'h0000;
         osc_ok_r     <= 1'b0;
      end
      else if (!osc_running)
      begin
         stable_cnt_r <= 13'h0000;
         osc_ok_r     <= 1'b0;
      end
      else if (xtal_tick && !osc_ok_r)
      begin
         stable_cnt_r <= 13'(stable_cnt_r + 13'h0001);
         osc_ok_r     <= stable_cnt_r == 13'(OSC_STABLE_TICKS - 1);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         act_r  <= 1'b0;
         sign_r <= 1'b0;
         mag_r  <= 7'h00;
         pend_r <= 3'h0;
         gap_r  <= 1'b0;
      end
      else
      begin
         if (trigger)
         begin
            act_r  <= 1'b1;
            sign_r <= cfg.offset[6];
            mag_r  <= mag_in;
         end
         else if (sec_tick && act_r && nsec_bin == rtc_pkg::LAST_SEC)
            act_r <= 1'b0;
         if (sec_tick && in_win)
            pend_r <= load_cnt;
         else if (corr_now)
            pend_r <= 3'(pend_r - 3'h1);
         if (low_wrap)
            gap_r <= corr_now;
      end
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata            <= rtc_pkg::READ_NONE;
         int_n                <= 1'b1;
         tick_64hz            <= 1'b0;
         tick_1hz             <= 1'b0;
         tick_1_60hz          <= 1'b0;
         divided_clock_output <= 1'b0;
      end
      else
      begin
         if (reg_req.rd)
            reg_rdata <= rd_mux;
         if (low_wrap)
            int_n <= !(corr_now && cfg.correction_irq_enable);
         tick_64hz            <= t64;
         tick_1hz             <= sec_tick;
         tick_1_60hz          <= min_tick;
         divided_clock_output <= !hi_cnt_r[9];
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_clear_write;
      wr_sec && !reg_req.wdata[rtc_pkg::HALT_BIT] && osc_ok_r && osc_running;
   endsequence
   sequence s_enter_last;
      sec_tick && act_r && !trigger && nsec_bin == rtc_pkg::LAST_SEC;
   endsequence

   a_int_needs_enable: assert property ($fell(int_n) |-> $past(corr_now && cfg.correction_irq_enable))
      else $error("indication without enabled correction");
   a_int_one_step: assert property ($rose(int_n) |-> $past(low_wrap) && $past(gap_r))
      else $error("indication width wrong");
   a_corr_spacing: assert property (corr_now |=> gap_r)
      else $error("corrections too close");
   a_pend_bound: assert property (pend_r <= rtc_pkg::MAX_PULSES)
      else $error("too many pulses queued");
   a_halt_when_stopped: assert property (!osc_ok_r |=> halt_r)
      else $error("stop flag not set while stopped");
   a_halt_clear_ok: assert property (s_clear_write |=> !halt_r)
      else $error("stop flag did not clear");
   a_osc_qualify: assert property (!osc_running |=> !osc_ok_r ##1 halt_r)
      else $error("oscillator accepted while stopped");
   a_sec_wrap: assert property (sec_tick && sec_wrap && !reg_req.wr |=> sec_r == 7'h00 && tick_1_60hz)
      else $error("seconds wrap wrong");
   a_fast_trigger: assert property (trigger |=> act_r && mag_r == $past(mag_in))
      else $error("fast cycle not started");
   a_last_second: assert property (s_enter_last |=> !act_r
      && pend_r == ((mag_r > rtc_pkg::LAST_SEC) ? extra[2:0] : 3'h0))
      else $error("second 59 load wrong");
   a_low_free: assert property (xtal_tick && !low_wrap |=> low_cnt_r == 5'($past(low_cnt_r) + 5'h01))
      else $error("fast stage disturbed");
   a_skip_step: assert property (corr_now && !sign_r && hi_cnt_r < 10'h3fe
      |=> hi_cnt_r == 10'($past(hi_cnt_r) + 10'h002))
      else $error("added pulse not applied");
   a_scratch_rw: assert property (wr_scr ##1 reg_req.rd && !reg_req.wr
      && reg_req.addr == rtc_pkg::ADDR_SCRATCH |=> reg_rdata == $past(reg_req.wdata, 2))
      else $error("scratch readback wrong");
   a_min_bit7: assert property (reg_req.rd && reg_req.addr == rtc_pkg::ADDR_MINUTES |=> !reg_rdata[7])
      else $error("minutes bit 7 set");
   a_sec_layout: assert property (reg_req.rd && reg_req.addr == rtc_pkg::ADDR_SECONDS
      |=> reg_rdata[7] == $past(halt_r))
      else $error("seconds layout wrong");

endmodule : rtc_core

// *** sim/rtc_xtal_model.sv ***
// Crystal front-end model: running indication and crystal ticks
`timescale 1ns/10ps
module rtc_xtal_model (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic run,
   output logic      xtal_tick,
   output logic      osc_running
);
   // One tick per sys_clk so a simulated second stays short; none while stopped
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         xtal_tick   <= 1'b0;
         osc_running <= 1'b0;
      end
      else
      begin
         osc_running <= run;
         xtal_tick   <= run;
      end
   end
endmodule : rtc_xtal_model

// *** sim/testbench.sv ***
// Self-checking testbench for the seconds/minutes and correction core
`timescale 1ns/10ps
module testbench;
   logic                   sys_clk;
   logic                   rst_n;
   logic                   run;
   logic                   xtal_tick;
   logic                   osc_running;
   rtc_pkg::rtc_reg_req_t  reg_req;
   rtc_pkg::rtc_corr_cfg_t cfg;
   logic [7:0]             reg_rdata;
   logic                   int_n, tick_64hz, tick_1hz, tick_1_60hz, divided_clock_output;
   int                     errors;
   int                     tests_run;

   rtc_xtal_model xtal_u (.sys_clk(sys_clk), .rst_n(rst_n), .run(run),
                          .xtal_tick(xtal_tick), .osc_running(osc_running));

   rtc_core #(.OSC_STABLE_TICKS(4)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
      .xtal_tick(xtal_tick), .osc_running(osc_running), .reg_req(reg_req), .cfg(cfg),
      .reg_rdata(reg_rdata), .int_n(int_n), .tick_64hz(tick_64hz), .tick_1hz(tick_1hz),
      .tick_1_60hz(tick_1_60hz), .divided_clock_output(divided_clock_output));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic step();
      @(posedge sys_clk);
      #1;
   endtask : step

   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check_byte

   task automatic check_count(input string what, input int exp, input int got);
      tests_run++;
      if (got != exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
      end
   endtask : check_count

   task automatic final_report();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      step();
      reg_req.wr    = 1'b1;
      reg_req.addr  = addr;
      reg_req.wdata = data;
      step();
      reg_req.wr    = 1'b0;
   endtask : reg_write

   // Read data is registered on the same edge that takes the strobe
   task automatic read_check(input logic [7:0] addr, input logic [7:0] exp, input string what);
      step();
      reg_req.rd   = 1'b1;
      reg_req.addr = addr;
      step();
      reg_req.rd   = 1'b0;
      step();
      check_byte(what, exp, reg_rdata);
   endtask : read_check

   task automatic wait_minute();
      int n;
      n = 0;
      while (tick_1_60hz !== 1'b1)
      begin
         step();
         n++;
         if (n > 40000)
         begin
            errors++;
            $display("CHECK FAILED minute tick expected pulse seen none");
            final_report();
         end
      end
   endtask : wait_minute

   // Runs one second to its 1 Hz tick; the writes at cycles 200 and 202 set up the next second
   task automatic run_second(input logic [7:0] sec_set, input logic [7:0] min_set,
                             input rtc_pkg::rtc_corr_cfg_t next_cfg, output int cyc,
                             output int falls, output int low, output int t64,
                             output int high);
      logic last_int;
      cyc      = 0;
      falls    = 0;
      low      = 0;
      t64      = 0;
      high     = 0;
      last_int = 1'b1;
      do
      begin
         step();
         cyc++;
         if (int_n === 1'b0) low++;
         if (int_n === 1'b0 && last_int === 1'b1) falls++;
         if (tick_64hz === 1'b1) t64++;
         if (divided_clock_output === 1'b1) high++;
         last_int = int_n;
         if (cyc == 200)
         begin
            reg_req = '{wr: 1'b1, rd: 1'b0, addr: 8'h05, wdata: min_set};
            cfg     = next_cfg;
         end
         if (cyc == 201) reg_req.wr = 1'b0;
         if (cyc == 202) reg_req = '{wr: 1'b1, rd: 1'b0, addr: 8'h04, wdata: sec_set};
         if (cyc == 203) reg_req.wr = 1'b0;
      end
      while (tick_1hz !== 1'b1 && cyc < 40000);
      if (cyc >= 40000)
      begin
         errors++;
         $display("CHECK FAILED second tick expected pulse seen none");
         final_report();
      end
   endtask : run_second

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_reset_values();
      read_check(8'h03, 8'h00, "scratch reset");
      read_check(8'h04, 8'h80, "seconds reset");
      read_check(8'h05, 8'h00, "minutes reset");
      read_check(8'h07, 8'h00, "unmapped read");
   endtask : test_reset_values

   task automatic test_scratch();
      reg_write(8'h03, 8'ha5);
      reg_write(8'h07, 8'h3c);
      read_check(8'h03, 8'ha5, "scratch a5");
      step();
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: 8'h03, wdata: 8'h3c};
      step();
      reg_req.wr = 1'b0;
      reg_req.rd = 1'b1;
      step();
      reg_req.rd = 1'b0;
      check_byte("scratch back to back", 8'h3c, reg_rdata);
      reg_write(8'h03, 8'h5a);
      read_check(8'h03, 8'h5a, "scratch 5a");
   endtask : test_scratch

   task automatic test_stop_flag();
      reg_write(8'h04, 8'h00);
      read_check(8'h04, 8'h80, "clear while stopped");
      run = 1'b1;
      repeat (10) step();
      reg_write(8'h04, 8'h00);
      read_check(8'h04, 8'h00, "clear while running");
      reg_write(8'h04, 8'h80);
      read_check(8'h04, 8'h80, "flag set by write");
   endtask : test_stop_flag

   task automatic test_minutes();
      reg_write(8'h05, 8'hd9);
      read_check(8'h05, 8'h59, "minutes bit7 unused");
   endtask : test_minutes

   // Offset +61: second 00 of minute 04 loses one 1024 Hz count, two more wait for 59
   task automatic test_fast_corr();
      int cyc;
      int falls;
      int low;
      int t64;
      int high;
      cfg = '{fast_mode: 1'b1, correction_irq_enable: 1'b1, offset: 7'h3d};
      reg_write(8'h05, 8'h03);
      reg_write(8'h04, 8'h59);
      wait_minute();
      run_second(8'h58, 8'h04, '{fast_mode: 1'b1, correction_irq_enable: 1'b0, offset: 7'h3d},
                 cyc, falls, low, t64, high);
      check_count("second 00 length", 32768 - 32, cyc);
      check_count("indication pulses", 1, falls);
      check_count("indication width", 32, low);
      check_count("64 Hz ticks", 64, t64);
      check_count("1 Hz output high", 16384 - 32, high);
      check_byte("no minute tick", 8'h00, {7'h00, tick_1_60hz});
   endtask : test_fast_corr

   // Second 59 reached from the written 58 inside the window: two counts dropped, indication masked
   task automatic test_last_second();
      int cyc;
      int falls;
      int low;
      int t64;
      int high;
      run_second(8'h59, 8'h07, '{fast_mode: 1'b1, correction_irq_enable: 1'b1, offset: 7'h7f},
                 cyc, falls, low, t64, high);
      check_count("second 59 length", 32768 - 64, cyc);
      check_count("masked indications", 0, falls);
      check_count("64 Hz ticks in 59", 64, t64);
      check_byte("minute tick", 8'h01, {7'h00, tick_1_60hz});
   endtask : test_last_second

   // Offset -1 at minute 08 holds one count, so the first 64 Hz tick is one count late
   task automatic test_slow_second();
      int cyc;
      int falls;
      logic last_int;
      cyc      = 0;
      falls    = 0;
      last_int = 1'b1;
      do
      begin
         step();
         cyc++;
         if (int_n === 1'b0 && last_int === 1'b1) falls++;
         last_int = int_n;
      end
      while (tick_64hz !== 1'b1 && cyc < 2000);
      check_count("first 64 Hz tick", 17 * 32, cyc);
      check_count("slow indication", 1, falls);
      check_byte("1 Hz output high", 8'h01, {7'h00, divided_clock_output});
      read_check(8'h05, 8'h08, "minute carry");
      read_check(8'h04, 8'h00, "seconds wrap");
   endtask : test_slow_second

   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   initial
   begin
      errors    = 0;
      tests_run = 0;
      rst_n     = 1'b0;
      run       = 1'b0;
      reg_req   = '0;
      cfg       = '0;
      repeat (4) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      test_reset_values();
      test_scratch();
      test_stop_flag();
      test_minutes();
      test_fast_corr();
      test_last_second();
      test_slow_second();
      final_report();
   end
endmodule : testbench
